// ==== can_btr_rflg.v ====
// CAN bit timing, sampling and receiver flag logic with an APB register slave
//
// Our own choices: the address map and the APB register port.
`default_nettype none
`include "can_btr_rflg_map.vh"

module can_btr_rflg (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire can_rx,
	input wire sleep_active,
	input wire wakeup_enable,
	input wire overrun_event,
	input wire receive_full_event,
	input wire [8:0] transmit_error_count,
	input wire [8:0] receive_error_count,
	output reg rx_bit_r,
	output reg sample_strobe_r,
	output reg bit_start_r,
	output reg init_acknowledge_r,
	output reg fifo_shift_block_r,
	output reg wakeup_irq_r,
	output reg error_irq_r,
	output reg receive_irq_r
);

	// One-hot bit phase states
	localparam [2:0] PH_SYNC = 3'b001;
	localparam [2:0] PH_SEG1 = 3'b010;
	localparam [2:0] PH_SEG2 = 3'b100;

	reg [5:0] quantum_prescaler_r;
	reg [7:0] bit_timing_segments_r;
	reg [7:0] receiver_interrupt_enables_r;
	reg init_request_r;
	reg wakeup_flag_r;
	reg status_change_flag_r;
	reg overrun_flag_r;
	reg receive_full_flag_r;
	reg [1:0] receiver_state_r;
	reg [1:0] transmitter_state_r;
	reg [5:0] presc_cnt_r;
	reg [3:0] seg_cnt_r;
	reg [2:0] phase_r;
	reg [2:0] phase_nxt;
	reg [3:0] seg_cnt_nxt;
	reg [1:0] rx_hist_r;
	reg [1:0] rx_state_nxt;
	reg [1:0] tx_state_nxt;
	reg [31:0] rdata_nxt;
	reg addr_ok;

	wire [7:0] wbyte = pwdata[7:0];
	wire init_mode = init_request_r & init_acknowledge_r;
	wire run_mode = ~init_request_r & ~init_acknowledge_r;
	wire wr_en = psel & penable & pready & pwrite;
	wire wr_timing = wr_en & (paddr == `ADDR_BIT_TIMING);
	wire wr_presc = wr_en & (paddr == `ADDR_PRESCALER);
	wire wr_flags = wr_en & (paddr == `ADDR_RX_FLAGS);
	wire wr_irq_en = wr_en & (paddr == `ADDR_RX_IRQ_EN);
	wire wr_init = wr_en & (paddr == `ADDR_INIT_CTRL);
	wire [3:0] first_segment_len = bit_timing_segments_r[`F_FIRST_SEGMENT_LEN_HI:`F_FIRST_SEGMENT_LEN_LO];
	wire [2:0] second_segment_len = bit_timing_segments_r[`F_SECOND_SEGMENT_LEN_HI:`F_SECOND_SEGMENT_LEN_LO];
	wire tq_tick = (presc_cnt_r == quantum_prescaler_r);
	wire seg1_last = tq_tick & phase_r[1] & (seg_cnt_r == first_segment_len);
	wire majority = (rx_hist_r[0] & rx_hist_r[1]) | (rx_hist_r[0] & can_rx) | (rx_hist_r[1] & can_rx);
	wire wake_cond = sleep_active & wakeup_enable & ~can_rx;
	wire state_moved = (rx_state_nxt != receiver_state_r) | (tx_state_nxt != transmitter_state_r);
	wire [7:0] flags_rd = {wakeup_flag_r, status_change_flag_r, receiver_state_r, transmitter_state_r,
		overrun_flag_r, receive_full_flag_r};

	// APB answer: pready rises in the access cycle, so every transfer is zero-wait
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & ~penable & ~pready;
			pslverr <= psel & ~penable & ~pready & ~addr_ok;
			if (psel & ~penable & ~pwrite)
				prdata <= rdata_nxt;
		end
	end

	// Read mux; reserved bits and unmapped addresses read zero
	always @* begin
		rdata_nxt = 32'h00000000;
		addr_ok = 1'b1;
		case (paddr)
			`ADDR_PRESCALER: rdata_nxt[`F_PRESC_HI:0] = quantum_prescaler_r;
			`ADDR_BIT_TIMING: rdata_nxt[7:0] = bit_timing_segments_r;
			`ADDR_RX_FLAGS: rdata_nxt[7:0] = flags_rd;
			`ADDR_RX_IRQ_EN: rdata_nxt[7:0] = receiver_interrupt_enables_r;
			`ADDR_INIT_CTRL: begin
				rdata_nxt[`F_INIT_REQ] = init_request_r;
				rdata_nxt[`F_INIT_ACK] = init_acknowledge_r;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// Init handshake; the acknowledge follows the request one clock later
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_request_r <= 1'b0;
			init_acknowledge_r <= 1'b0;
		end else begin
			if (wr_init)
				init_request_r <= wbyte[`F_INIT_REQ];
			init_acknowledge_r <= init_request_r;
		end
	end

	// Timing registers accept writes only inside init mode so the bit engine never sees a torn setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_timing_segments_r <= `RST_BYTE;
			quantum_prescaler_r <= `RST_PRESC;
		end else if (init_mode) begin
			if (wr_timing)
				bit_timing_segments_r <= wbyte;
			if (wr_presc)
				quantum_prescaler_r <= wbyte[`F_PRESC_HI:0];
		end
	end

	// Interrupt enables: held at reset in init mode, writable only when fully out of it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			receiver_interrupt_enables_r <= `RST_BYTE;
		else if (init_mode)
			receiver_interrupt_enables_r <= `RST_BYTE;
		else if (wr_irq_en & run_mode)
			receiver_interrupt_enables_r <= wbyte;
	end

	// Quantum clock: count 0..prescaler, one tick every prescaler+1 clocks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			presc_cnt_r <= `RST_PRESC;
		else if (init_mode | tq_tick)
			presc_cnt_r <= `RST_PRESC;
		else
			presc_cnt_r <= presc_cnt_r + 6'h01;
	end

	// Bit phase sequencing: one sync quantum, then first_segment_len+1 and second_segment_len+1 quanta
	always @* begin
		phase_nxt = phase_r;
		seg_cnt_nxt = seg_cnt_r;
		if (tq_tick) begin
			case (phase_r)
				PH_SYNC: begin
					phase_nxt = PH_SEG1;
					seg_cnt_nxt = 4'h0;
				end
				PH_SEG1: begin
					if (seg_cnt_r == first_segment_len) begin
						phase_nxt = PH_SEG2;
						seg_cnt_nxt = 4'h0;
					end else begin
						seg_cnt_nxt = seg_cnt_r + 4'h1;
					end
				end
				PH_SEG2: begin
					if (seg_cnt_r == {1'b0, second_segment_len}) begin
						phase_nxt = PH_SYNC;
						seg_cnt_nxt = 4'h0;
					end else begin
						seg_cnt_nxt = seg_cnt_r + 4'h1;
					end
				end
				default: begin
					phase_nxt = PH_SYNC;
					seg_cnt_nxt = 4'h0;
				end
			endcase
		end
	end

	// Bit engine is parked in sync while in init mode
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= PH_SYNC;
			seg_cnt_r <= 4'h0;
		end else if (init_mode) begin
			phase_r <= PH_SYNC;
			seg_cnt_r <= 4'h0;
		end else begin
			phase_r <= phase_nxt;
			seg_cnt_r <= seg_cnt_nxt;
		end
	end

	// Sampling: history holds the two quanta before the sample point; no resync, bus assumed aligned
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_hist_r <= 2'h3;
			rx_bit_r <= 1'b1;
			sample_strobe_r <= 1'b0;
			bit_start_r <= 1'b0;
		end else begin
			sample_strobe_r <= seg1_last & ~init_mode;
			bit_start_r <= tq_tick & phase_r[0] & ~init_mode;
			if (tq_tick)
				rx_hist_r <= {rx_hist_r[0], can_rx};
			if (seg1_last & ~init_mode) begin
				if (bit_timing_segments_r[`F_TRIPLE_SAMPLE_SELECT])
					rx_bit_r <= majority;
				else
					rx_bit_r <= can_rx;
			end
		end
	end

	// Error state from counters; transmitter bus-off drags the receiver along
	always @* begin
		if (receive_error_count <= `LIM_WARN)
			rx_state_nxt = `ST_OK;
		else if (receive_error_count <= `LIM_PASSIVE)
			rx_state_nxt = `ST_WARN;
		else
			rx_state_nxt = `ST_PASSIVE;
		if (transmit_error_count <= `LIM_WARN)
			tx_state_nxt = `ST_OK;
		else if (transmit_error_count <= `LIM_PASSIVE)
			tx_state_nxt = `ST_WARN;
		else if (transmit_error_count <= `LIM_BUSOFF)
			tx_state_nxt = `ST_PASSIVE;
		else
			tx_state_nxt = `ST_BUSOFF;
		if (tx_state_nxt == `ST_BUSOFF)
			rx_state_nxt = `ST_BUSOFF;
	end

	// State fields ignore bus writes and keep tracking even in init mode
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receiver_state_r <= `RST_STATE;
			transmitter_state_r <= `RST_STATE;
		end else if (~status_change_flag_r | init_mode) begin
			receiver_state_r <= rx_state_nxt;
			transmitter_state_r <= tx_state_nxt;
		end
	end

	// Flags: set beats clear; a clear is refused while the cause still stands
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wakeup_flag_r <= 1'b0;
			status_change_flag_r <= 1'b0;
			overrun_flag_r <= 1'b0;
			receive_full_flag_r <= 1'b0;
		end else if (init_mode) begin
			wakeup_flag_r <= 1'b0;
			status_change_flag_r <= 1'b0;
			overrun_flag_r <= 1'b0;
			receive_full_flag_r <= 1'b0;
		end else begin
			if (wake_cond)
				wakeup_flag_r <= 1'b1;
			else if (wr_flags & run_mode & wbyte[`F_WAKE])
				wakeup_flag_r <= 1'b0;
			if (state_moved & ~status_change_flag_r)
				status_change_flag_r <= 1'b1;
			else if (wr_flags & run_mode & wbyte[`F_CSC] & ~state_moved)
				status_change_flag_r <= 1'b0;
			if (overrun_event)
				overrun_flag_r <= 1'b1;
			else if (wr_flags & run_mode & wbyte[`F_OVR])
				overrun_flag_r <= 1'b0;
			if (receive_full_event)
				receive_full_flag_r <= 1'b1;
			else if (wr_flags & run_mode & wbyte[`F_RXF])
				receive_full_flag_r <= 1'b0;
		end
	end

	// Requests stay pending as long as flag and enable are both set
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wakeup_irq_r <= 1'b0;
			error_irq_r <= 1'b0;
			receive_irq_r <= 1'b0;
			fifo_shift_block_r <= 1'b0;
		end else begin
			wakeup_irq_r <= wakeup_flag_r & receiver_interrupt_enables_r[`F_WAKE];
			error_irq_r <= (status_change_flag_r & receiver_interrupt_enables_r[`F_CSC])
				| (overrun_flag_r & receiver_interrupt_enables_r[`F_OVR]);
			receive_irq_r <= receive_full_flag_r & receiver_interrupt_enables_r[`F_RXF];
			fifo_shift_block_r <= receive_full_flag_r;
		end
	end

endmodule // can_btr_rflg
`default_nettype wire

// ==== can_btr_rflg_map.vh ====
// Register map, field positions, reset values and thresholds for the CAN bit timing and receiver flag block
//
// How it works
// - TRIPLE_SAMPLE_SELECT clear single sample, set three-sample majority
// - Second segment bits 6:4, length code plus one
// - First segment bits 3:0, length code plus one
// - Bit is sync quantum plus both segments
// - Timing writes only in init, reads always
// - Flag write one clears, zero ignored
// - Flag clears only once its cause ceased
// - Each flag gated by enable onto request
// - Init mode forces flags reset, refuses writes
// - Receiver and transmitter state fields read-only
// - Wake-up flag bit 7 on sleeping bus activity
// - Status-change flag bit 6 on state change
// - State fields frozen while status-change flag pending
// - Receiver state 00 up to 96, 01 to 127
// - Transmitter state 00 up to 96, 01 to 127
// - State fields keep tracking during init mode
// - Overrun flag bit 1 on receive overrun
// - Receive-full flag bit 0 blocks next shift
// - Six-bit prescaler divides clock by value plus one
`ifndef CAN_BTR_RFLG_MAP_VH
`define CAN_BTR_RFLG_MAP_VH

// Byte addresses on the APB bus
`define ADDR_PRESCALER 8'h00
`define ADDR_BIT_TIMING 8'h04
`define ADDR_RX_FLAGS 8'h08
`define ADDR_RX_IRQ_EN 8'h0c
`define ADDR_INIT_CTRL 8'h10

// Field positions
`define F_TRIPLE_SAMPLE_SELECT 7
`define F_SECOND_SEGMENT_LEN_HI 6
`define F_SECOND_SEGMENT_LEN_LO 4
`define F_FIRST_SEGMENT_LEN_HI 3
`define F_FIRST_SEGMENT_LEN_LO 0
`define F_PRESC_HI 5
`define F_WAKE 7
`define F_CSC 6
`define F_RSTATE_HI 5
`define F_RSTATE_LO 4
`define F_TSTATE_HI 3
`define F_TSTATE_LO 2
`define F_OVR 1
`define F_RXF 0
`define F_INIT_REQ 0
`define F_INIT_ACK 1

// Reset values
`define RST_BYTE 8'h00
`define RST_STATE 2'h0
`define RST_PRESC 6'h00

// Error state thresholds and codes
`define LIM_WARN 9'h060
`define LIM_PASSIVE 9'h07f
`define LIM_BUSOFF 9'h0ff
`define ST_OK 2'h0
`define ST_WARN 2'h1
`define ST_PASSIVE 2'h2
`define ST_BUSOFF 2'h3

`endif

// ==== can_btr_rflg_asserts.sv ====
// Port-level assertions for the CAN bit timing and receiver flag block
`default_nettype none
module can_btr_rflg_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic receive_full_event,
	input wire logic rx_bit_r,
	input wire logic sample_strobe_r,
	input wire logic bit_start_r,
	input wire logic init_acknowledge_r,
	input wire logic fifo_shift_block_r,
	input wire logic wakeup_irq_r,
	input wire logic error_irq_r,
	input wire logic receive_irq_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Every register stays reachable: zero wait states, single-cycle answer
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no answer after setup");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("answer held too long");
	// Acknowledge only rises two edges after a request write
	property p_ack;
		$rose(init_acknowledge_r) |-> $past(psel && penable && pwrite && paddr == 8'h10 && pwdata[0], 2);
	endproperty
	a_ack: assert property (p_ack) else $error("acknowledge without request");
	// Init mode holds every flag and enable at reset
	property p_init_clear;
		init_acknowledge_r [*3] |-> !(fifo_shift_block_r || error_irq_r || wakeup_irq_r || receive_irq_r);
	endproperty
	a_init_clear: assert property (p_init_clear) else $error("flag survives init mode");
	property p_rxf; receive_full_event && !init_acknowledge_r |=> ##1 fifo_shift_block_r; endproperty
	a_rxf: assert property (p_rxf) else $error("receive full does not block");
	// A pending request only drops after a write or an init entry
	property p_err_hold;
		error_irq_r && !psel && !$past(psel) && !init_acknowledge_r && !$past(init_acknowledge_r) |=> error_irq_r;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error request dropped");
	// Shortest bit is three quanta of one clock
	property p_strobe; sample_strobe_r |=> !sample_strobe_r [*2]; endproperty
	a_strobe: assert property (p_strobe) else $error("samples too close");
	property p_rx; $changed(rx_bit_r) |-> sample_strobe_r; endproperty
	a_rx: assert property (p_rx) else $error("bit changed off the sample point");
	c_bit: cover property (bit_start_r);
	c_err: cover property (error_irq_r);
	c_slverr: cover property (pslverr);
endmodule // can_btr_rflg_asserts
bind can_btr_rflg can_btr_rflg_asserts chk (.*);
`default_nettype wire

// ==== can_node_model.sv ====
// Model of the other CAN nodes: bus level and the error counts they provoke
`default_nettype none
module can_node_model (
	input wire logic pclk,
	input wire logic dominant,
	input wire logic [8:0] tec_set,
	input wire logic [8:0] rec_set,
	output var logic can_rx = 1'b1,
	output var logic [8:0] transmit_error_count = 9'h000,
	output var logic [8:0] receive_error_count = 9'h000
);
	timeunit 1ns;
	timeprecision 1ps;
	// Wired bus idles recessive; counters take the values the bench sets, one clock later
	always @(posedge pclk) begin
		can_rx <= !dominant;
		transmit_error_count <= tec_set;
		receive_error_count <= rec_set;
	end
endmodule // can_node_model
`default_nettype wire

// ==== can_btr_rflg_test.sv ====
// Self-checking bench for the CAN bit timing and receiver flag block
`default_nettype none
module can_btr_rflg_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, q;
	logic sleep_active = 1'b0, wakeup_enable = 1'b0, overrun_event = 1'b0, receive_full_event = 1'b0;
	logic dominant = 1'b0;
	logic [8:0] tec_set = 9'h000, rec_set = 9'h000;
	wire [31:0] prdata;
	wire [8:0] transmit_error_count, receive_error_count;
	wire pready, pslverr, can_rx, rx_bit_r, sample_strobe_r, bit_start_r, init_acknowledge_r;
	wire fifo_shift_block_r, wakeup_irq_r, error_irq_r, receive_irq_r;
	int num_errors = 0, n_tests = 0, cyc = 0, t0;
	can_btr_rflg dut (.*);
	can_node_model node (.*);
	always #4 pclk = ~pclk;
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_sim;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer: request held until pready is seen high at a rising edge, answer taken there
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic s_timing;
		apb(1'b1, 8'h04, 32'hff);
		rd(8'h04, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({q[30:0], e}, 32'h1);
		apb(1'b1, 8'h10, 32'h1);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h04, 32'h13);
		rd(8'h04, 32'h13);
		rd(8'h00, 32'h1);
		// The bit engine is parked in init mode, so leave it before timing a bit
		apb(1'b1, 8'h10, 32'h0);
		while (bit_start_r !== 1'b1) @(negedge pclk);
		t0 = cyc;
		@(negedge pclk);
		while (bit_start_r !== 1'b1) @(negedge pclk);
		chk(cyc - t0, 14);
		dominant <= 1'b1;
		repeat (40) @(posedge pclk);
		chk({31'h0, rx_bit_r}, 32'h0);
		// Triple sampling may only be chosen inside init mode
		apb(1'b1, 8'h10, 32'h1);
		apb(1'b1, 8'h04, 32'h93);
		apb(1'b1, 8'h10, 32'h0);
		dominant <= 1'b0;
		repeat (40) @(posedge pclk);
		chk({31'h0, rx_bit_r}, 32'h1);
		// One dominant quantum at the sample point is outvoted by the two quanta before it
		@(posedge pclk);
		while (sample_strobe_r !== 1'b1) @(posedge pclk);
		repeat (11) @(posedge pclk);
		dominant <= 1'b1;
		repeat (2) @(posedge pclk);
		dominant <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({31'h0, rx_bit_r}, 32'h1);
	endtask
	task automatic s_flags;
		apb(1'b1, 8'h0c, 32'hff);
		overrun_event <= 1'b1;
		receive_full_event <= 1'b1;
		@(posedge pclk);
		overrun_event <= 1'b0;
		receive_full_event <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({error_irq_r, receive_irq_r, fifo_shift_block_r}, 32'h7);
		apb(1'b1, 8'h08, 32'h0);
		rd(8'h08, 32'h03);
		apb(1'b1, 8'h08, 32'h3);
		rd(8'h08, 32'h0);
		sleep_active <= 1'b1;
		wakeup_enable <= 1'b1;
		dominant <= 1'b1;
		// Bus level, then flag, then request: three register stages before it shows
		repeat (4) @(posedge pclk);
		chk({31'h0, wakeup_irq_r}, 32'h1);
		apb(1'b1, 8'h08, 32'h80);
		rd(8'h08, 32'h80);
		sleep_active <= 1'b0;
		dominant <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b1, 8'h08, 32'h80);
		rd(8'h08, 32'h0);
	endtask
	task automatic s_state;
		rec_set <= 9'd97;
		repeat (3) @(posedge pclk);
		rd(8'h08, 32'h50);
		chk({31'h0, error_irq_r}, 32'h1);
		rec_set <= 9'd130;
		tec_set <= 9'd97;
		repeat (3) @(posedge pclk);
		apb(1'b1, 8'h08, 32'h70);
		rd(8'h08, 32'h50);
		rec_set <= 9'd97;
		tec_set <= 9'd0;
		repeat (3) @(posedge pclk);
		apb(1'b1, 8'h08, 32'h40);
		rd(8'h08, 32'h10);
		tec_set <= 9'd97;
		repeat (3) @(posedge pclk);
		rd(8'h08, 32'h54);
	endtask
	task automatic s_init;
		apb(1'b1, 8'h10, 32'h1);
		rd(8'h10, 32'h3);
		rd(8'h08, 32'h14);
		tec_set <= 9'd0;
		repeat (3) @(posedge pclk);
		rd(8'h08, 32'h10);
		apb(1'b1, 8'h0c, 32'hff);
		rd(8'h0c, 32'h0);
		apb(1'b1, 8'h10, 32'h0);
		tec_set <= 9'd300;
		repeat (3) @(posedge pclk);
		rd(8'h08, 32'h7c);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Reset, then each scenario in turn
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h04, 32'h0);
		s_timing;
		s_flags;
		s_state;
		s_init;
		end_sim;
	end
endmodule // can_btr_rflg_test
`default_nettype wire
